// ### iwcd_pkg.sv
/*
  Shared definitions for the instruction word cycle decoder: opcode
  classes, operand field positions, range limits, extra-cycle counts,
  state encoding and the packed carriers between the files.
  Assumes 24-bit program words with the opcode class in the top byte.
*/
package iwcd_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Word geometry
  localparam int unsigned WORD_W = 24;  // Program word width
  localparam int unsigned INSN_W = 48;  // Double-word instruction width
  localparam int unsigned OPC_LSB = 16; // Opcode class, low bit
  localparam int unsigned OPC_W = 8;    // Opcode class width
  localparam logic [OPC_W-1:0] EXT_UPPER = 8'h00; // Upper byte of word two
  localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000; // Absent word two

  ////////////////////////////////////////////////////////////////////////
  // Opcode classes
  localparam logic [OPC_W-1:0] OPC_NOP = 8'h00;      // Also lone word two
  localparam logic [OPC_W-1:0] OPC_CALL = 8'h02;     // Double-word call
  localparam logic [OPC_W-1:0] OPC_GOTO = 8'h04;     // Double-word jump
  localparam logic [OPC_W-1:0] OPC_BRA_COND = 8'h30; // Conditional branch
  localparam logic [OPC_W-1:0] OPC_BRA = 8'h37;      // Unconditional branch
  localparam logic [OPC_W-1:0] OPC_WIN_RD = 8'h80;   // Program space read
  localparam logic [OPC_W-1:0] OPC_SKIP = 8'ha4;     // Test and skip
  localparam logic [OPC_W-1:0] OPC_TBLRD = 8'hba;    // Table read
  localparam logic [OPC_W-1:0] OPC_MOVD = 8'hbe;     // Double-word move

  ////////////////////////////////////////////////////////////////////////
  // Extra no-operation cycles
  localparam int unsigned CNT_W = 2;
  localparam logic [CNT_W-1:0] EXTRA_NONE = 2'h0;
  localparam logic [CNT_W-1:0] EXTRA_PC = 2'h1;
  localparam logic [CNT_W-1:0] EXTRA_COND = 2'h1;
  localparam logic [CNT_W-1:0] EXTRA_TBL = 2'h1;
  localparam logic [CNT_W-1:0] EXTRA_WIN = 2'h1;
  localparam logic [CNT_W-1:0] EXTRA_MOVD = 2'h1;
  localparam logic [CNT_W-1:0] CNT_LAST = 2'h1;

  ////////////////////////////////////////////////////////////////////////
  // Operand fields of the first word, and address bits of word two
  localparam int unsigned REG_W = 4;       // Working register index
  localparam int unsigned IMM10_W = 10;    // Ten-bit immediates
  localparam int unsigned FREG_W = 16;     // File register field
  localparam int unsigned PADR_W = 23;     // Program address immediate
  localparam int unsigned PADR_HI_W = 7;   // Address bits in word two
  localparam int unsigned SEXT_W = 16;     // Sign-extended immediate
  localparam int unsigned BASE_LSB = 0;
  localparam int unsigned BITPOS_LSB = 12;
  localparam int unsigned IMM10_LSB = 4;
  localparam int unsigned BYTE_BIT = 14;
  localparam int unsigned ACC_BIT = 15;
  localparam int unsigned WBT_LSB = 4;
  localparam int unsigned FREG_LSB = 0;
  localparam int unsigned PADR_LO_W = 16;
  localparam logic [IMM10_W-1:0] IMM10_BYTE_MAX = 10'h0ff;
  localparam logic [FREG_W-1:0] FREG_MAX = 16'h1fff;
  localparam logic [1:0] WBT_DIRECT = 2'h0;  // W13 itself
  localparam logic [1:0] WBT_POSTINC = 2'h1; // [W13] then add step
  localparam logic [REG_W-1:0] WBT_REG = 4'hd;
  localparam logic [1:0] WBT_STEP = 2'h2;

  ////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    ST_FETCH = 3'h0, // Taking a new word
    ST_EXT   = 3'h1, // Taking the extension word
    ST_NOP   = 3'h3, // Issuing filler cycles
    ST_SKIP  = 3'h2, // Discarding a skipped word
    ST_SKEXT = 3'h6  // Discarding a skipped extension
  } iwcd_fsm_t;

  typedef struct packed {
    logic [REG_W-1:0] base_working_reg;
    logic [REG_W-1:0] bit_position_field;
    logic [IMM10_W-1:0] ten_bit_unsigned_imm;
    logic byte_mode;
    logic [SEXT_W-1:0] signed_ten_bit_imm;
    logic [PADR_W-1:0] program_address_imm;
    logic [FREG_W-1:0] file_reg_addr;
    logic acc_sel_b;
    logic [REG_W-1:0] accumulator_writeback_target;
    logic wbt_indirect;
    logic [1:0] wbt_step;
  } iwcd_fields_t;

  typedef struct packed {
    logic ext_not_zero; // Word two upper byte not clear
    logic imm_range;    // Byte immediate above limit
    logic addr_lsb;     // Odd program address
    logic freg_range;   // File address outside data space
    logic wbt_code;     // Unknown write-back code
  } iwcd_errs_t;

  typedef struct packed {
    logic exec;  // Instruction executes this cycle
    logic nop;   // Filler cycle
    logic dbl;   // Executed instruction is double-word
    logic [INSN_W-1:0] insn;
    iwcd_fields_t f;
    iwcd_errs_t e;
  } iwcd_issue_t;

  typedef struct packed {
    iwcd_fsm_t fsm;
    logic [WORD_W-1:0] first;
    logic [CNT_W-1:0] cnt;
    iwcd_issue_t iss;
  } iwcd_regs_t;

  // Opcode classes that take a second word
  function automatic logic iwcd_is_dw(input logic [OPC_W-1:0] op);
    return (op == OPC_GOTO) || (op == OPC_CALL);
  endfunction : iwcd_is_dw

endpackage : iwcd_pkg

// ### iwcd_field_check.sv
/*
  Operand field extractor and range checker for one candidate
  instruction. Purely combinational; the caller registers the result.
  Assumes the instruction is given as first word over second word.
*/
`timescale 1ns/1ns
`default_nettype none
module iwcd_field_check
  import iwcd_pkg::*;
(
  input wire logic [INSN_W-1:0] insn_i,
  input wire logic dbl_i,
  output iwcd_fields_t fields_o,
  output iwcd_errs_t errs_o
);

  logic [WORD_W-1:0] w1; // First word
  logic [WORD_W-1:0] w2; // Second word
  assign w1 = insn_i[INSN_W-1:WORD_W];
  assign w2 = insn_i[WORD_W-1:0];

  //////////////////////////////////////////////////////////////////////////
  // Field split and checks
  always_comb begin
    fields_o = '0;
    errs_o = '0;
    fields_o.base_working_reg = w1[BASE_LSB +: REG_W];
    fields_o.bit_position_field = w1[BITPOS_LSB +: REG_W];
    fields_o.ten_bit_unsigned_imm = w1[IMM10_LSB +: IMM10_W];
    fields_o.byte_mode = w1[BYTE_BIT];
    // Two's complement sign extension
    fields_o.signed_ten_bit_imm = {{(SEXT_W-IMM10_W){w1[IMM10_LSB+IMM10_W-1]}},
                                   w1[IMM10_LSB +: IMM10_W]};
    fields_o.program_address_imm = {w2[0 +: PADR_HI_W], w1[0 +: PADR_LO_W]};
    fields_o.file_reg_addr = w1[FREG_LSB +: FREG_W];
    fields_o.acc_sel_b = w1[ACC_BIT];
    // Write-back target is W13 or [W13] with post-increment
    case (w1[WBT_LSB +: 2])
      WBT_DIRECT: begin
        fields_o.accumulator_writeback_target = WBT_REG;
      end
      WBT_POSTINC: begin
        fields_o.accumulator_writeback_target = WBT_REG;
        fields_o.wbt_indirect = 1'b1;
        fields_o.wbt_step = WBT_STEP;
      end
      default: begin
        errs_o.wbt_code = 1'b1;
      end
    endcase
    // Upper byte of word two must be clear
    errs_o.ext_not_zero = dbl_i && (w2[OPC_LSB +: OPC_W] != EXT_UPPER);
    // Byte mode limits the ten-bit immediate
    errs_o.imm_range = w1[BYTE_BIT] &&
                       (w1[IMM10_LSB +: IMM10_W] > IMM10_BYTE_MAX);
    // Program addresses are even
    errs_o.addr_lsb = dbl_i && w1[0];
    // File register operand stays in data space
    errs_o.freg_range = w1[FREG_LSB +: FREG_W] > FREG_MAX;
  end

endmodule : iwcd_field_check
`default_nettype wire

// ### iwcd_decoder.sv
/*
  Instruction word cycle decoder: takes program words, joins double-word
  instructions, issues one execute cycle per instruction and inserts
  filler no-operation cycles for branches, reads, skips and moves.
  Assumes words and the datapath answers cond_true_i and skip_take_i
  come from logic on the same clock, valid in the cycle a word is taken.
*/
// Functional notes
// - Double-word is 48 bits, upper byte zero
// - Lone second word executes as no-operation
// - Double-word instructions take exactly two cycles
// - Single-word one cycle unless branch, read, move or taken skip
// - Extra cycles are issued as no-operations
// - Taken skip costs two or three cycles
// - Double-word move takes two cycles
// - Bit position is four bits, 0 to 15
// - Ten-bit immediate limited in byte mode
// - Program address immediate is always even
// - File register address up to 0x1FFF
// - Write-back target W13 or post-incremented [W13]
// - Signed ten-bit immediate spans -512 to 511
// - Accumulator field picks A or B
// - Base register field picks W0 to W15
`timescale 1ns/1ns
`default_nettype none
module iwcd_decoder
  import iwcd_pkg::*;
#(
  parameter logic [CNT_W-1:0] PC_EXTRA = EXTRA_PC // Filler cycles after an unconditional branch
) (
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  input wire logic fw_valid_i,
  input wire logic [WORD_W-1:0] fw_word_i,
  input wire logic cond_true_i,
  input wire logic skip_take_i,
  output logic fw_ready_o,
  output iwcd_issue_t iss_o
);

  //////////////////////////////////////////////////////////////////////////
  // Elaboration check
  if (PC_EXTRA == EXTRA_NONE) begin : g_bad_pc_extra
    $error("PC_EXTRA must be at least one cycle");
  end

  //////////////////////////////////////////////////////////////////////////
  // State and helper nets
  iwcd_regs_t q; // All state
  iwcd_regs_t d; // Next state
  logic take; // Word accepted this cycle
  logic [OPC_W-1:0] op; // Opcode class of the offered word
  logic [INSN_W-1:0] cand; // Candidate instruction for field checks
  logic cand_dbl; // Candidate is a joined double-word
  logic [CNT_W-1:0] extra; // Filler cycles for the offered word
  iwcd_fields_t cand_f; // Decoded candidate fields
  iwcd_errs_t cand_e; // Candidate range errors

  // Words are refused only while filler cycles run
  assign fw_ready_o = (q.fsm != ST_NOP);
  assign take = fw_valid_i && fw_ready_o;
  assign op = fw_word_i[OPC_LSB +: OPC_W];
  assign iss_o = q.iss;

  // Join the held first word with the extension when one is due
  assign cand_dbl = (q.fsm == ST_EXT);
  assign cand = cand_dbl ? {q.first, fw_word_i} : {fw_word_i, WORD_ZERO};

  //////////////////////////////////////////////////////////////////////////
  // Operand fields
  iwcd_field_check u_fields (
    .insn_i(cand),
    .dbl_i(cand_dbl),
    .fields_o(cand_f),
    .errs_o(cand_e)
  );

  //////////////////////////////////////////////////////////////////////////
  // Filler cycle count per opcode class
  always_comb begin
    extra = EXTRA_NONE;
    case (op)
      // Taken condition adds one cycle
      OPC_BRA_COND: begin
        extra = cond_true_i ? EXTRA_COND : EXTRA_NONE;
      end
      // Program counter change
      OPC_BRA: begin
        extra = PC_EXTRA;
      end
      // Table read
      OPC_TBLRD: begin
        extra = EXTRA_TBL;
      end
      // Program space window read
      OPC_WIN_RD: begin
        extra = EXTRA_WIN;
      end
      // Double-word move spends two cycles
      OPC_MOVD: begin
        extra = EXTRA_MOVD;
      end
      default: begin
        extra = EXTRA_NONE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // Sequencer next state
  always_comb begin
    d = q;
    d.iss.exec = 1'b0;
    d.iss.nop = 1'b0;
    case (q.fsm)
      // New word: classify and dispatch
      ST_FETCH: begin
        if (take) begin
          if (op == OPC_NOP) begin
            // Lone extension word does nothing
            d.iss.nop = 1'b1;
          end else if (iwcd_is_dw(op)) begin
            // Hold the first word, spend cycle one fetching
            d.first = fw_word_i;
            d.iss.nop = 1'b1;
            d.fsm = ST_EXT;
          end else begin
            // Single-word executes now
            d.iss.exec = 1'b1;
            d.iss.dbl = 1'b0;
            d.iss.insn = cand;
            d.iss.f = cand_f;
            d.iss.e = cand_e;
            if ((op == OPC_SKIP) && skip_take_i) begin
              d.fsm = ST_SKIP;
            end else if (extra != EXTRA_NONE) begin
              d.cnt = extra;
              d.fsm = ST_NOP;
            end
          end
        end
      end
      // Extension arrives: execute the joined 48 bits
      ST_EXT: begin
        if (take) begin
          d.iss.exec = 1'b1;
          d.iss.dbl = 1'b1;
          d.iss.insn = cand;
          d.iss.f = cand_f;
          d.iss.e = cand_e;
          d.fsm = ST_FETCH;
        end
      end
      // Filler cycles, fetch held off
      ST_NOP: begin
        d.iss.nop = 1'b1;
        d.cnt = q.cnt - CNT_LAST;
        if (q.cnt == CNT_LAST) begin
          d.fsm = ST_FETCH;
        end
      end
      // Skipped word becomes a filler cycle
      ST_SKIP: begin
        if (take) begin
          d.iss.nop = 1'b1;
          d.fsm = iwcd_is_dw(op) ? ST_SKEXT : ST_FETCH;
        end
      end
      // Skipped extension costs one more filler
      ST_SKEXT: begin
        if (take) begin
          d.iss.nop = 1'b1;
          d.fsm = ST_FETCH;
        end
      end
      default: begin
        d.fsm = ST_FETCH;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  logic dw_take; // Double-word first word taken in fetch
  assign dw_take = (q.fsm == ST_FETCH) && take && iwcd_is_dw(op);

  property p_ext_upper;
    (q.fsm == ST_EXT) && take |=> iss_o.exec && iss_o.dbl &&
      (iss_o.e.ext_not_zero == ($past(op) != EXT_UPPER));
  endproperty
  a_ext_upper: assert property (p_ext_upper)
    else $error("extension upper byte check wrong");

  property p_lone_ext;
    (q.fsm == ST_FETCH) && take && (op == OPC_NOP) |=>
      iss_o.nop && !iss_o.exec;
  endproperty
  a_lone_ext: assert property (p_lone_ext)
    else $error("lone extension word not a no-operation");

  // No filler follows: a later nop only comes from a newly taken word
  property p_dw_two;
    dw_take ##1 fw_valid_i |=> iss_o.exec && iss_o.dbl && fw_ready_o ##1
      (iss_o.nop == $past(take && ((op == OPC_NOP) || iwcd_is_dw(op))));
  endproperty
  a_dw_two: assert property (p_dw_two)
    else $error("double-word not two cycles");

  property p_dw_join;
    dw_take |=> (q.fsm == ST_EXT) && !iss_o.exec &&
      (q.first == $past(fw_word_i));
  endproperty
  a_dw_join: assert property (p_dw_join)
    else $error("first word not held for extension");

  property p_cond_branch;
    (q.fsm == ST_FETCH) && take && (op == OPC_BRA_COND) && cond_true_i |=>
      iss_o.exec && !fw_ready_o ##1 iss_o.nop && fw_ready_o;
  endproperty
  a_cond_branch: assert property (p_cond_branch)
    else $error("taken branch cycle count wrong");

  property p_single;
    (q.fsm == ST_FETCH) && take && (extra == EXTRA_NONE) &&
      (op != OPC_NOP) && !iwcd_is_dw(op) && (op != OPC_SKIP) |=>
      iss_o.exec && fw_ready_o;
  endproperty
  a_single: assert property (p_single)
    else $error("plain instruction not one cycle");

  property p_filler;
    (q.fsm == ST_NOP) |-> !fw_ready_o ##1 iss_o.nop && !iss_o.exec;
  endproperty
  a_filler: assert property (p_filler)
    else $error("filler cycle not a no-operation");

  property p_skip_one;
    (q.fsm == ST_FETCH) && take && (op == OPC_SKIP) && skip_take_i ##1
      take && !iwcd_is_dw(op) |=> iss_o.nop && (q.fsm == ST_FETCH);
  endproperty
  a_skip_one: assert property (p_skip_one)
    else $error("skip over single word not two cycles");

  property p_skip_two;
    (q.fsm == ST_FETCH) && take && (op == OPC_SKIP) && skip_take_i ##1
      take && iwcd_is_dw(op) ##1 take |=> iss_o.nop && (q.fsm == ST_FETCH);
  endproperty
  a_skip_two: assert property (p_skip_two)
    else $error("skip over double word not three cycles");

  property p_movd;
    (q.fsm == ST_FETCH) && take && (op == OPC_MOVD) |=>
      iss_o.exec && !fw_ready_o ##1 iss_o.nop && fw_ready_o;
  endproperty
  a_movd: assert property (p_movd)
    else $error("double-word move not two cycles");

  property p_imm_byte;
    iss_o.exec && iss_o.f.byte_mode && !iss_o.e.imm_range |->
      iss_o.f.ten_bit_unsigned_imm <= IMM10_BYTE_MAX;
  endproperty
  a_imm_byte: assert property (p_imm_byte)
    else $error("byte immediate above limit unflagged");

  property p_addr_even;
    iss_o.exec && iss_o.dbl && !iss_o.e.addr_lsb |->
      !iss_o.f.program_address_imm[0];
  endproperty
  a_addr_even: assert property (p_addr_even)
    else $error("odd program address unflagged");

  property p_freg;
    iss_o.exec && !iss_o.e.freg_range |-> iss_o.f.file_reg_addr <= FREG_MAX;
  endproperty
  a_freg: assert property (p_freg)
    else $error("file address outside data space unflagged");

  property p_wbt;
    iss_o.exec && !iss_o.e.wbt_code |->
      (iss_o.f.accumulator_writeback_target == WBT_REG) &&
      (iss_o.f.wbt_step == (iss_o.f.wbt_indirect ? WBT_STEP : 2'h0));
  endproperty
  a_wbt: assert property (p_wbt)
    else $error("write-back target not W13 form");

  property p_simm;
    iss_o.exec |-> ($signed(iss_o.f.signed_ten_bit_imm) >= -16'sd512) &&
      ($signed(iss_o.f.signed_ten_bit_imm) <= 16'sd511);
  endproperty
  a_simm: assert property (p_simm)
    else $error("signed immediate out of range");

  // Main scenarios
  c_dw: cover property (dw_take ##1 take ##1 iss_o.dbl);
  c_skip_dw: cover property ((q.fsm == ST_SKEXT) && take);
  c_branch: cover property ((q.fsm == ST_NOP) && (q.cnt == CNT_LAST));
  c_lone: cover property ((q.fsm == ST_FETCH) && take && (op == OPC_NOP));

endmodule : iwcd_decoder
`default_nettype wire

// ### iwcd_decoder_test.sv
/*
  Self-checking bench for the instruction word cycle decoder: a cycle
  model built from integers compares exec, nop and ready at every cycle
  and the decoded fields on execute cycles, under directed and seeded random words.
  Assumes the decoder with its default filler count of one cycle.
*/
`timescale 1ns/1ns
`default_nettype none
module iwcd_decoder_test;
  import iwcd_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Signals and bench state
  logic ref_clk_i;
  logic arst_n_i;
  logic fw_valid_i;
  logic [WORD_W-1:0] fw_word_i;
  logic cond_true_i;
  logic skip_take_i;
  logic fw_ready_o;
  iwcd_issue_t iss_o;
  int mismatches;
  int num_checks;
  int seed;
  int mst; // Model state: 0 fetch, 1 ext, 2 filler, 3 skip, 4 skip ext
  logic e_exec, e_nop, e_dbl; // Expected pulses and width flag
  logic [INSN_W-1:0] e_insn; // Expected joined instruction
  logic [WORD_W-1:0] first; // Held first word of a double
  logic [7:0] ops [10] = '{8'h00, 8'h02, 8'h04, 8'h10, 8'h30, 8'h37,
                           8'h80, 8'ha4, 8'hba, 8'hbe};

  // Device under test
  iwcd_decoder u_iwcd_decoder (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .fw_valid_i(fw_valid_i),
    .fw_word_i(fw_word_i),
    .cond_true_i(cond_true_i),
    .skip_take_i(skip_take_i),
    .fw_ready_o(fw_ready_o),
    .iss_o(iss_o)
  );

  // 10 MHz clock
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  // Compare and close
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic test_done();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////
  // Cycle model, one step per clock edge
  always @(posedge ref_clk_i or negedge arst_n_i) begin : model
    logic [7:0] op;
    logic dw;
    op = fw_word_i[23:16];
    dw = (op == 8'h02) || (op == 8'h04);
    if (!arst_n_i) begin
      mst = 0;
      e_exec = 1'b0;
      e_nop = 1'b0;
      e_dbl = 1'b0;
      e_insn = '0;
    end else begin
      e_exec = 1'b0;
      e_nop = 1'b0;
      if (mst == 2) begin
        // Filler cycle after a multi-cycle instruction
        e_nop = 1'b1;
        mst = 0;
      end else if (fw_valid_i) begin
        if (mst >= 3) begin
          // Skipped word, and its extension if double
          e_nop = 1'b1;
          mst = (mst == 3 && dw) ? 4 : 0;
        end else if (mst == 1) begin
          // Extension joins the first word
          e_exec = 1'b1;
          e_dbl = 1'b1;
          e_insn = {first, fw_word_i};
          mst = 0;
        end else if (dw) begin
          e_nop = 1'b1;
          first = fw_word_i;
          mst = 1;
        end else if (op == 8'h00) begin
          e_nop = 1'b1;
        end else begin
          e_exec = 1'b1;
          e_dbl = 1'b0;
          e_insn = {fw_word_i, 24'h000000};
          if (op == 8'h37 || op == 8'h80 || op == 8'hba || op == 8'hbe ||
              (op == 8'h30 && cond_true_i)) begin
            mst = 2;
          end else if (op == 8'ha4 && skip_take_i) begin
            mst = 3;
          end
        end
      end
    end
  end

  // Compare at mid-cycle where all outputs have settled
  always @(negedge ref_clk_i) begin : compare
    logic [WORD_W-1:0] f1, ex;
    f1 = e_insn[47:24];
    ex = e_insn[23:0];
    chk(64'(iss_o.exec), 64'(e_exec));
    chk(64'(iss_o.nop), 64'(e_nop));
    chk(64'(fw_ready_o), 64'(mst != 2));
    if (e_exec) begin
      chk(64'(iss_o.dbl), 64'(e_dbl));
      chk(64'(iss_o.insn), 64'(e_insn));
      chk(64'(iss_o.f.base_working_reg), 64'(f1[3:0]));
      chk(64'(iss_o.f.bit_position_field), 64'(f1[15:12]));
      chk(64'(iss_o.f.ten_bit_unsigned_imm), 64'(f1[13:4]));
      chk(64'(iss_o.f.byte_mode), 64'(f1[14]));
      chk(64'(iss_o.e.imm_range),
          64'(f1[14] && f1[13:4] > 10'h0ff));
      chk(64'(iss_o.f.signed_ten_bit_imm),
          64'({{6{f1[13]}}, f1[13:4]}));
      chk(64'(iss_o.f.program_address_imm),
          64'({ex[6:0], f1[15:0]}));
      chk(64'(iss_o.f.file_reg_addr), 64'(f1[15:0]));
      chk(64'(iss_o.e.freg_range), 64'(f1[15:0] > 16'h1fff));
      chk(64'(iss_o.f.acc_sel_b), 64'(f1[15]));
      chk(64'(iss_o.e.wbt_code), 64'(f1[5]));
      if (!f1[5]) begin
        // Direct or post-incremented write-back register
        chk(64'(iss_o.f.accumulator_writeback_target), 64'(4'hd));
        chk(64'(iss_o.f.wbt_indirect), 64'(f1[4]));
        chk(64'(iss_o.f.wbt_step), 64'(f1[4] ? 2'h2 : 2'h0));
      end
      // Single words carry no extension, so both flags stay clear
      chk(64'(iss_o.e.ext_not_zero), 64'(ex[23:16] != 8'h00));
      chk(64'(iss_o.e.addr_lsb), 64'(e_dbl && f1[0]));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Drivers: change inputs 1 ns after the rising edge
  task automatic send(input logic [23:0] w, input logic c, input logic s);
    int n;
    fw_valid_i = 1'b1;
    fw_word_i = w;
    cond_true_i = c;
    skip_take_i = s;
    n = 0;
    while (!fw_ready_o && n < 20) begin
      @(posedge ref_clk_i);
      #1;
      n++;
    end
    @(posedge ref_clk_i);
    #1;
  endtask : send

  task automatic idle(input int n);
    fw_valid_i = 1'b0;
    fw_word_i = 24'($random(seed));
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask : idle

  // Watchdog sized well above the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    mismatches++;
    test_done();
  end

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin : main
    int r, k;
    mismatches = 0;
    num_checks = 0;
    seed = 32'ha373a42e;
    arst_n_i = 1'b0;
    fw_valid_i = 1'b0;
    fw_word_i = 24'h000000;
    cond_true_i = 1'b0;
    skip_take_i = 1'b0;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk(64'(iss_o != '0), 64'h0);
    arst_n_i = 1'b1;
    // Every class, back to back, conditions true
    for (k = 0; k < 10; k++) begin
      send({ops[k], 16'h5a3c}, 1'b1, 1'b1);
      if (ops[k] == 8'h02 || ops[k] == 8'h04) send(24'h00007f, 1'b0, 1'b0);
      send(24'h10ffff, 1'b0, 1'b0);
    end
    // Field boundaries: byte immediate, file address, write-back codes
    send(24'h104ff0, 1'b0, 1'b0);
    send(24'h105000, 1'b0, 1'b0);
    send(24'h101fff, 1'b0, 1'b0);
    send(24'h102020, 1'b0, 1'b0);
    send(24'h308030, 1'b0, 1'b0);
    // Double with dirty upper byte and odd address, then lone word two
    send(24'h040001, 1'b0, 1'b0);
    send(24'h3c0055, 1'b0, 1'b0);
    send(24'h000123, 1'b0, 1'b0);
    // Skip over single, skip over double, skip not taken
    send(24'ha40000, 1'b0, 1'b1);
    send(24'h101234, 1'b0, 1'b0);
    send(24'ha40000, 1'b0, 1'b1);
    send(24'h021000, 1'b0, 1'b0);
    send(24'h000001, 1'b0, 1'b0);
    send(24'ha40000, 1'b0, 1'b0);
    send(24'h101234, 1'b0, 1'b0);
    idle(2);
    // Seeded random traffic with gaps
    for (k = 0; k < 400; k++) begin
      r = $random(seed);
      send({ops[$unsigned(r) % 10], r[31:16]}, r[7], r[8]);
      if (ops[$unsigned(r) % 10] == 8'h02 || ops[$unsigned(r) % 10] == 8'h04)
        send({(r[11:9] == 3'h0) ? r[15:8] : 8'h00, r[15:0]}, 1'b0, 1'b0);
      if (r[12]) idle(1);
    end
    // Reset in mid-run, then traffic again
    send(24'h370000, 1'b0, 1'b0);
    arst_n_i = 1'b0;
    idle(2);
    arst_n_i = 1'b1;
    send(24'h040002, 1'b0, 1'b0);
    send(24'h000003, 1'b0, 1'b0);
    idle(3);
    test_done();
  end

endmodule : iwcd_decoder_test
`default_nettype wire
